/* File: logic/shpp_pkg.sv */
// Package with register map, field positions and shared types of the port.
package shpp_pkg;

    localparam logic [7:0] SHPP_OFF_CTRL = 8'h00;
    localparam logic [7:0] SHPP_OFF_OUT = 8'h04;
    localparam logic [7:0] SHPP_OFF_BIDIR = 8'h08;
    localparam logic [7:0] SHPP_OFF_LATCH = 8'h0c;
    localparam logic [7:0] SHPP_OFF_DIR = 8'h10;
    localparam logic [7:0] SHPP_OFF_MODE = 8'h14;

    localparam int SHPP_BIT_FLAG = 7;
    localparam int SHPP_BIT_IRQEN = 6;
    localparam int SHPP_BIT_WOR = 5;
    localparam int SHPP_BIT_FULL_HANDSHAKE_SELECT = 4;
    localparam int SHPP_BIT_OIN = 3;
    localparam int SHPP_BIT_PLS = 2;
    localparam int SHPP_BIT_EGA = 1;
    localparam int SHPP_BIT_STROBE_POLARITY_SELECT = 0;

    localparam logic [7:0] SHPP_CTRL_RST = 8'h00;
    localparam logic [7:0] SHPP_BYTE_RST = 8'h00;
    localparam logic [7:0] SHPP_CTRL_WMASK = 8'h7f;

    localparam real SHPP_CLK_NS = 25.0;
    localparam real SHPP_PULSE_NS = 50.0;
    localparam logic [1:0] SHPP_PULSE_CYC =
        2'(int'($ceil(SHPP_PULSE_NS / SHPP_CLK_NS)));

    typedef struct packed {
        logic [7:0] dout;
        logic [7:0] oe;
    } shpp_pins_t;

    typedef struct packed {
        logic write;
        logic read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } shpp_acc_t;

endpackage : shpp_pkg

/* File: logic/shpp_sync.sv */
// Three-stage synchroniser with agreement-based change detection.
`timescale 1ns/10ps
module shpp_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic din,
    output logic level,
    output logic rise,
    output logic fall
);
    import shpp_pkg::*;

    logic [2:0] sh_r;
    logic [2:0] sh_nxt;
    logic lvl_r;
    logic lvl_nxt;

    // Stage one feeds only stage two; a change counts once two and three agree.
    always_comb begin
        sh_nxt = {sh_r[1:0], din};
        lvl_nxt = (sh_r[1] == sh_r[2]) ? sh_r[2] : lvl_r;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_r <= 3'h7;
            lvl_r <= 1'b1;
        end else begin
            sh_r <= sh_nxt;
            lvl_r <= lvl_nxt;
        end
    end

    assign level = lvl_r;
    assign rise = lvl_nxt & ~lvl_r;
    assign fall = ~lvl_nxt & lvl_r;

endmodule : shpp_sync

/* File: logic/shpp_pulse.sv */
// Strobe pulse timer of a fixed number of bus clock cycles.
`timescale 1ns/10ps
module shpp_pulse (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic kill,
    output logic busy
);
    import shpp_pkg::*;

    logic [1:0] cnt_r;
    logic [1:0] cnt_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        if (kill) begin
            cnt_nxt = 2'h0;
        end else if (start) begin
            cnt_nxt = SHPP_PULSE_CYC;
        end else if (cnt_r != 2'h0) begin
            cnt_nxt = cnt_r - 2'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 2'h0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign busy = (cnt_r != 2'h0);

endmodule : shpp_pulse

/* File: logic/shpp_port.sv */
// Strobed and full-handshake parallel port with an APB register slave.
// Notes on behaviour
// - Each output port write in simple mode pulses the output strobe two cycles.
// - Polarity bit 0 makes the output strobe active low, 1 active high.
// - Each selected input strobe edge latches the bidirectional pins, except in output handshake.
// - Bidirectional lines stay general purpose I/O under direction bits, except while output handshake drives all lines.
// - Input handshake: strobe asserted when ready, negated after data latched.
// - Input handshake: strobe reasserted after latched register read.
// - Output handshake: write to latched register asserts the output strobe.
// - Three-state variation drives all lines while input strobe is active.
// - Three-state variation negates strobe after input strobe trailing edge.
// - Three-state variation drives every line; no static inputs mixed in.
// - Handshake and strobe functions work only in single-chip mode.
// - Control bit 7 is read only; the rest read and write.
// - Strobe flag sets on each selected input strobe edge.
// - Flag clears by control read seeing it, then latched read or write.
// - Interrupt request is the flag gated by its enable bit.
// - Wired-OR bit makes all eight pins open drain.
// - Handshake bit 0 picks simple strobe, 1 full handshake.
// - Direction bit picks input (0) or output (1) handshake.
// - Pulse bit 0 interlocked to the input edge, 1 two-cycle pulse.
// - Edge bit 0 falling edge, high drives; 1 rising edge, low drives.
`timescale 1ns/10ps
module shpp_port (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ack_strobe_in,
    output logic ready_strobe_out,
    output logic [7:0] output_data_port,
    input wire logic [7:0] bidir_in,
    output logic [7:0] bidir_out,
    output logic [7:0] bidir_oe,
    output logic irq
);
    import shpp_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Upper address bits must be zero, so aliases cannot hide software faults.
    function automatic logic hit(input logic [31:0] a, input logic [7:0] o);
        hit = (a[31:8] == 24'h0) && (a[7:0] == o);
    endfunction : hit

    logic [7:0] ctrl_r;
    logic [7:0] ctrl_nxt;
    logic [7:0] outp_r;
    logic [7:0] outp_nxt;
    logic [7:0] bid_r;
    logic [7:0] bid_nxt;
    logic [7:0] latch_r;
    logic [7:0] latch_nxt;
    logic [7:0] dir_r;
    logic [7:0] dir_nxt;
    logic single_r;
    logic single_nxt;
    logic armed_r;
    logic armed_nxt;
    logic ready_strobe_out_r;
    logic ready_strobe_out_nxt;
    logic drive_r;
    logic drive_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic pready_r;
    logic pready_nxt;
    logic pslverr_r;
    logic pslverr_nxt;
    logic [7:0] pin_out_r;
    logic [7:0] pin_out_nxt;
    logic [7:0] pin_oe_r;
    logic [7:0] pin_oe_nxt;
    logic ready_out_r;
    logic ready_out_nxt;
    logic irq_r;
    logic irq_nxt;
    logic [7:0] pins_sync;
    logic ack_strobe_in_lvl;
    logic ack_strobe_in_rise;
    logic ack_strobe_in_fall;
    logic pulse_busy;
    logic pulse_start;
    shpp_acc_t acc;
    shpp_pins_t pins;
    logic sel_edge;
    logic trail_edge;
    logic ack_strobe_in_active;
    logic full_handshake_select;
    logic handshake_direction_select;
    logic pulsed_strobe_select;
    logic wr_latch;
    logic rd_latch;
    logic wr_out;
    logic enter_in_hs;

    ////////////////////////////////////////////////////////////////////////
    shpp_sync u_ack_strobe_in (
        .pclk(pclk),
        .presetn(presetn),
        .din(ack_strobe_in),
        .level(ack_strobe_in_lvl),
        .rise(ack_strobe_in_rise),
        .fall(ack_strobe_in_fall)
    );

    // Each pin has its own synchroniser, matched in delay to the strobe.
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_pin
            shpp_sync u_pin (
                .pclk(pclk),
                .presetn(presetn),
                .din(bidir_in[gi]),
                .level(pins_sync[gi]),
                .rise(),
                .fall()
            );
        end
    endgenerate

    // Leaving single-chip mode cuts any running pulse short at once.
    shpp_pulse u_pulse (
        .pclk(pclk),
        .presetn(presetn),
        .start(pulse_start),
        .kill(!single_r),
        .busy(pulse_busy)
    );

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        acc.write = psel && penable && pwrite && !pready_r;
        acc.read = psel && penable && !pwrite && !pready_r;
        acc.addr = paddr[7:0];
        acc.wdata = pwdata[7:0];
        full_handshake_select = ctrl_r[SHPP_BIT_FULL_HANDSHAKE_SELECT];
        handshake_direction_select = ctrl_r[SHPP_BIT_OIN] && full_handshake_select;
        pulsed_strobe_select = ctrl_r[SHPP_BIT_PLS] && full_handshake_select;
        // The active drive level ends on the selected edge, so both coincide.
        sel_edge = ctrl_r[SHPP_BIT_EGA] ? ack_strobe_in_rise : ack_strobe_in_fall;
        trail_edge = sel_edge;
        ack_strobe_in_active = ctrl_r[SHPP_BIT_EGA] ? !ack_strobe_in_lvl : ack_strobe_in_lvl;
        wr_latch = acc.write && hit(paddr, SHPP_OFF_LATCH);
        rd_latch = acc.read && hit(paddr, SHPP_OFF_LATCH);
        wr_out = acc.write && hit(paddr, SHPP_OFF_OUT);
        // Only entry from another mode signals ready; a rewrite inside the
        // mode must not claim readiness while a byte is still unread.
        enter_in_hs = acc.write && hit(paddr, SHPP_OFF_CTRL)
            && acc.wdata[SHPP_BIT_FULL_HANDSHAKE_SELECT] && !acc.wdata[SHPP_BIT_OIN]
            && !(full_handshake_select && !handshake_direction_select);
    end

    // Two-cycle pulse in simple mode and in pulsed handshake.
    assign pulse_start = single_r
        && ((!full_handshake_select && wr_out)
        || (pulsed_strobe_select && !handshake_direction_select && rd_latch)
        || (pulsed_strobe_select && handshake_direction_select && wr_latch));

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        ctrl_nxt = ctrl_r;
        outp_nxt = outp_r;
        bid_nxt = bid_r;
        latch_nxt = latch_r;
        dir_nxt = dir_r;
        single_nxt = single_r;
        armed_nxt = armed_r;
        ready_strobe_out_nxt = ready_strobe_out_r;
        drive_nxt = drive_r;
        prdata_nxt = prdata_r;
        pready_nxt = 1'b0;
        pslverr_nxt = 1'b0;
        if (acc.write || acc.read) begin
            pready_nxt = 1'b1;
            // An unmapped offset answers with an error and changes nothing.
            pslverr_nxt = !(hit(paddr, SHPP_OFF_CTRL)
                || hit(paddr, SHPP_OFF_OUT)
                || hit(paddr, SHPP_OFF_BIDIR)
                || hit(paddr, SHPP_OFF_LATCH)
                || hit(paddr, SHPP_OFF_DIR)
                || hit(paddr, SHPP_OFF_MODE));
        end
        if (acc.write) begin
            if (hit(paddr, SHPP_OFF_CTRL)) begin
                ctrl_nxt = (ctrl_r & ~SHPP_CTRL_WMASK)
                    | (acc.wdata & SHPP_CTRL_WMASK);
            end
            if (hit(paddr, SHPP_OFF_OUT)) begin
                outp_nxt = acc.wdata;
            end
            if (hit(paddr, SHPP_OFF_BIDIR)) begin
                bid_nxt = acc.wdata;
            end
            if (hit(paddr, SHPP_OFF_DIR)) begin
                dir_nxt = acc.wdata;
            end
            if (hit(paddr, SHPP_OFF_MODE)) begin
                single_nxt = acc.wdata[0];
            end
        end
        if (acc.read) begin
            prdata_nxt = 32'h0;
            if (hit(paddr, SHPP_OFF_CTRL)) begin
                prdata_nxt[7:0] = ctrl_r;
                armed_nxt = ctrl_r[SHPP_BIT_FLAG];
            end
            if (hit(paddr, SHPP_OFF_OUT)) begin
                prdata_nxt[7:0] = outp_r;
            end
            // Input lines return the pin; output lines the written data.
            if (hit(paddr, SHPP_OFF_BIDIR)) begin
                prdata_nxt[7:0] = (dir_r & bid_r) | (~dir_r & pins_sync);
            end
            if (hit(paddr, SHPP_OFF_LATCH)) begin
                prdata_nxt[7:0] = latch_r;
            end
            if (hit(paddr, SHPP_OFF_DIR)) begin
                prdata_nxt[7:0] = dir_r;
            end
            if (hit(paddr, SHPP_OFF_MODE)) begin
                prdata_nxt[7:0] = {7'h0, single_r};
            end
        end
        if (handshake_direction_select && wr_latch) begin
            latch_nxt = acc.wdata;
        end
        // Flag clear on the second step of the sequence.
        // Only a control read that saw the flag arms it; other orders keep it.
        if (armed_r && ((handshake_direction_select && wr_latch) || (!handshake_direction_select && rd_latch))) begin
            ctrl_nxt[SHPP_BIT_FLAG] = 1'b0;
            armed_nxt = 1'b0;
        end
        if (single_r) begin
            // Pins pass the same stages as the strobe, so byte and edge align.
            if (!handshake_direction_select && sel_edge) begin
                latch_nxt = pins_sync;
            end
            // Setting wins over a clear in the same cycle.
            if (sel_edge) begin
                ctrl_nxt[SHPP_BIT_FLAG] = 1'b1;
            end
            // Interlocked strobe level of the full handshake modes.
            if (full_handshake_select && !handshake_direction_select) begin
                if (sel_edge) begin
                    ready_strobe_out_nxt = 1'b0;
                end else if (rd_latch) begin
                    ready_strobe_out_nxt = 1'b1;
                end
            end else if (full_handshake_select && handshake_direction_select) begin
                if (wr_latch) begin
                    ready_strobe_out_nxt = 1'b1;
                end else if (!pulsed_strobe_select && trail_edge) begin
                    ready_strobe_out_nxt = 1'b0;
                end
            end else begin
                ready_strobe_out_nxt = 1'b0;
            end
            // Entering input handshake raises the strobe: ready for a byte.
            if (enter_in_hs) begin
                ready_strobe_out_nxt = 1'b1;
            end
            // Whole port driven while acknowledge is active, all lines alike.
            drive_nxt = full_handshake_select && handshake_direction_select && ack_strobe_in_active;
        end else begin
            ready_strobe_out_nxt = 1'b0;
            drive_nxt = 1'b0;
            ctrl_nxt[SHPP_BIT_FLAG] = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        pins.dout = drive_r ? latch_r : bid_r;
        pins.oe = drive_r ? 8'hff : dir_r;
        pin_out_nxt = pins.dout;
        pin_oe_nxt = pins.oe;
        if (ctrl_r[SHPP_BIT_WOR]) begin
            // Open drain only pulls low; external pull-ups supply the high.
            pin_out_nxt = 8'h00;
            pin_oe_nxt = pins.oe & ~pins.dout;
        end
        ready_out_nxt = ((full_handshake_select && !pulsed_strobe_select) ? ready_strobe_out_nxt : pulse_busy)
            ^ ~ctrl_r[SHPP_BIT_STROBE_POLARITY_SELECT];
        // The request follows the flag's next value so it drops with a clear.
        irq_nxt = ctrl_nxt[SHPP_BIT_FLAG] && ctrl_r[SHPP_BIT_IRQEN];
    end

    // Outputs come from flops so that no decode glitch reaches a pin.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= SHPP_CTRL_RST;
            outp_r <= SHPP_BYTE_RST;
            bid_r <= SHPP_BYTE_RST;
            latch_r <= SHPP_BYTE_RST;
            dir_r <= SHPP_BYTE_RST;
            single_r <= 1'b1;
            armed_r <= 1'b0;
            ready_strobe_out_r <= 1'b0;
            drive_r <= 1'b0;
            prdata_r <= 32'h0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            pin_out_r <= SHPP_BYTE_RST;
            pin_oe_r <= SHPP_BYTE_RST;
            ready_out_r <= 1'b1;
            irq_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            outp_r <= outp_nxt;
            bid_r <= bid_nxt;
            latch_r <= latch_nxt;
            dir_r <= dir_nxt;
            single_r <= single_nxt;
            armed_r <= armed_nxt;
            ready_strobe_out_r <= ready_strobe_out_nxt;
            drive_r <= drive_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            pin_out_r <= pin_out_nxt;
            pin_oe_r <= pin_oe_nxt;
            ready_out_r <= ready_out_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign output_data_port = outp_r;
    assign bidir_out = pin_out_r;
    assign bidir_oe = pin_oe_r;
    assign ready_strobe_out = ready_out_r;
    assign irq = irq_r;

endmodule : shpp_port

/* File: verif/shpp_port_sva.sv */
// Checker of port behaviour seen at the top module's ports.
`timescale 1ns/10ps
module shpp_port_sva import shpp_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic ack_strobe_in,
    input wire logic ready_strobe_out,
    input wire logic [7:0] output_data_port,
    input wire logic [7:0] bidir_in,
    input wire logic [7:0] bidir_out,
    input wire logic [7:0] bidir_oe,
    input wire logic irq
);
    logic acc;
    logic act;
    logic [7:0] wlo;
    logic [7:0] ctrl_r, ctrl_nxt, dir_r, dir_nxt;
    logic mode_r, mode_nxt;
    assign acc = psel && penable && pready && pwrite && !pslverr;
    assign act = ready_strobe_out == ctrl_r[SHPP_BIT_STROBE_POLARITY_SELECT];
    assign wlo = pwdata[7:0];
    // Shadows give the checks the active level and mode without peeking.
    always_comb begin
        ctrl_nxt = ctrl_r;
        dir_nxt = dir_r;
        mode_nxt = mode_r;
        if (acc && paddr[7:0] == SHPP_OFF_CTRL)
            ctrl_nxt = wlo & SHPP_CTRL_WMASK;
        if (acc && paddr[7:0] == SHPP_OFF_DIR)
            dir_nxt = wlo;
        if (acc && paddr[7:0] == SHPP_OFF_MODE)
            mode_nxt = wlo[0];
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= SHPP_CTRL_RST;
            dir_r <= SHPP_BYTE_RST;
            mode_r <= 1'b1;
        end else begin
            ctrl_r <= ctrl_nxt;
            dir_r <= dir_nxt;
            mode_r <= mode_nxt;
        end
    end
    ////////////////////////////////////////////////////////////
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_out_wr;
        acc && paddr[7:0] == SHPP_OFF_OUT;
    endsequence
    sequence s_pulse;
        act ##1 act ##1 !act;
    endsequence
    a_out_data: assert property (
        s_out_wr |=> output_data_port == $past(wlo))
        else $error("output port data wrong");
    a_simple_pulse: assert property (
        s_out_wr ##0 (mode_r && !ctrl_r[SHPP_BIT_FULL_HANDSHAKE_SELECT]) |-> ##[1:2] s_pulse)
        else $error("strobe pulse not two cycles");
    a_ctrl_read: assert property (
        psel && penable && pready && !pwrite && !pslverr
        && paddr[7:0] == SHPP_OFF_CTRL |-> prdata[6:0] == ctrl_r[6:0]
        && prdata[31:8] == 24'h0)
        else $error("control read back wrong");
    a_irq_gate: assert property (
        (!ctrl_r[SHPP_BIT_IRQEN])[*3] |-> !irq)
        else $error("interrupt while disabled");
    a_mode_quiet: assert property (
        ($stable(ctrl_r) && !mode_r)[*3] |-> !act && !irq)
        else $error("strobe active outside mode");
    a_open_drain: assert property (
        ctrl_r[SHPP_BIT_WOR][*3] |-> bidir_out == 8'h00)
        else $error("open drain drives high");
    a_dir_follow: assert property (
        ($stable(dir_r) && mode_r && !ctrl_r[SHPP_BIT_WOR]
        && !ctrl_r[SHPP_BIT_FULL_HANDSHAKE_SELECT])[*3] |-> bidir_oe == dir_r)
        else $error("drive enables differ from direction");
    a_apb_answer: assert property (
        psel && penable && !pready |=> pready)
        else $error("bus answer late");
endmodule : shpp_port_sva
bind shpp_port shpp_port_sva i_shpp_port_sva (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .ack_strobe_in, .ready_strobe_out, .output_data_port, .bidir_in,
    .bidir_out, .bidir_oe, .irq);

/* File: verif/shpp_periph.sv */
// Model of the outside system that strobes bytes in and out.
`timescale 1ns/10ps
module shpp_periph (
    input wire logic pclk,
    input wire logic [7:0] bidir_out,
    input wire logic [7:0] bidir_oe,
    output logic ack_strobe_in,
    output logic [7:0] bidir_in
);
    logic [7:0] drv;
    logic drv_en;
    // Lines nobody drives float to the pull-up level, never the old data.
    assign bidir_in = (bidir_oe & bidir_out)
        | (~bidir_oe & (drv_en ? drv : 8'hff));
    initial begin
        ack_strobe_in = 1'b1;
        drv = 8'h00;
        drv_en = 1'b0;
    end
    task automatic idle(input logic lvl);
        @(posedge pclk);
        ack_strobe_in <= lvl;
    endtask : idle
    // Data settles well before the strobe; pins are read while it is active.
    task automatic put(input logic [7:0] d, input logic en,
        input logic lvl, output logic [7:0] seen);
        @(posedge pclk);
        drv <= d;
        drv_en <= en;
        repeat (6) @(posedge pclk);
        ack_strobe_in <= lvl;
        repeat (8) @(posedge pclk);
        seen = bidir_in;
        ack_strobe_in <= ~lvl;
        drv_en <= 1'b0;
    endtask : put
endmodule : shpp_periph

/* File: verif/shpp_port_tb.sv */
// Self-checking testbench of the strobed parallel port.
`timescale 1ns/10ps
module shpp_port_tb;
    import shpp_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata;
    logic ack_strobe_in, ready_strobe_out, irq, act, er;
    logic [7:0] output_data_port, bidir_in, bidir_out, bidir_oe, rv, seen;
    int err_total, checked, n;
    shpp_port i_shpp_port (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .ack_strobe_in,
        .ready_strobe_out, .output_data_port, .bidir_in, .bidir_out,
        .bidir_oe, .irq);
    shpp_periph i_shpp_periph (.pclk, .bidir_out, .bidir_oe,
        .ack_strobe_in, .bidir_in);
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    ////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : close_out
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [7:0] wd, output logic [7:0] rd, output logic e);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {24'h0, a};
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20) begin
            err_total++;
            close_out();
        end
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d, rv, er);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        apb(1'b0, a, 8'h00, rv, er);
        chk(rv, exp);
    endtask : rd
    task automatic cnt;
        n = 0;
        repeat (10) begin
            @(posedge pclk);
            if (ready_strobe_out === act) n++;
        end
    endtask : cnt
    task automatic chs(input logic exp);
        repeat (8) @(posedge pclk);
        chk({7'h0, ready_strobe_out}, {7'h0, exp});
    endtask : chs
    ////////////////////////////////////////////////////////////
    task automatic t_regs;
        rd(SHPP_OFF_CTRL, SHPP_CTRL_RST);
        rd(SHPP_OFF_MODE, 8'h01);
        chk({7'h0, ready_strobe_out}, 8'h01);
        wr(SHPP_OFF_CTRL, 8'hff);
        rd(SHPP_OFF_CTRL, 8'h7f);
        apb(1'b0, 8'h18, 8'h00, rv, er);
        chk({7'h0, er}, 8'h01);
    endtask : t_regs
    task automatic t_simple;
        for (int p = 0; p < 2; p++) begin
            wr(SHPP_OFF_CTRL, 8'(p));
            act = p[0];
            wr(SHPP_OFF_OUT, 8'ha5 ^ {8{p[0]}});
            cnt();
            chk(8'(n), 8'h02);
            chk(output_data_port, 8'ha5 ^ {8{p[0]}});
        end
    endtask : t_simple
    task automatic t_latch;
        wr(SHPP_OFF_DIR, 8'h0f);
        wr(SHPP_OFF_BIDIR, 8'h3c);
        wr(SHPP_OFF_CTRL, 8'h40);
        repeat (4) @(posedge pclk);
        chk(bidir_oe, 8'h0f);
        i_shpp_periph.put(8'h5a, 1'b1, 1'b0, seen);
        repeat (8) @(posedge pclk);
        chk({7'h0, irq}, 8'h01);
        rd(SHPP_OFF_CTRL, 8'hc0);
        rd(SHPP_OFF_LATCH, 8'h5c);
        rd(SHPP_OFF_CTRL, 8'h40);
        rd(SHPP_OFF_BIDIR, 8'hfc);
    endtask : t_latch
    task automatic t_in_hs;
        wr(SHPP_OFF_DIR, 8'h00);
        wr(SHPP_OFF_CTRL, 8'h10);
        chs(1'b0);
        i_shpp_periph.put(8'h3e, 1'b1, 1'b0, seen);
        chs(1'b1);
        rd(SHPP_OFF_LATCH, 8'h3e);
        chs(1'b0);
        wr(SHPP_OFF_CTRL, 8'h14);
        act = 1'b0;
        i_shpp_periph.put(8'h81, 1'b1, 1'b0, seen);
        repeat (8) @(posedge pclk);
        apb(1'b0, SHPP_OFF_LATCH, 8'h00, rv, er);
        cnt();
        chk(8'(n), 8'h02);
        wr(SHPP_OFF_CTRL, 8'h02);
        rd(SHPP_OFF_CTRL, 8'h82);
        rd(SHPP_OFF_LATCH, 8'h81);
        i_shpp_periph.idle(1'b0);
        repeat (8) @(posedge pclk);
        rd(SHPP_OFF_CTRL, 8'h02);
        i_shpp_periph.put(8'h24, 1'b1, 1'b1, seen);
        repeat (8) @(posedge pclk);
        rd(SHPP_OFF_CTRL, 8'h82);
        rd(SHPP_OFF_LATCH, 8'h24);
    endtask : t_in_hs
    task automatic t_out_hs;
        wr(SHPP_OFF_CTRL, 8'h18);
        i_shpp_periph.idle(1'b0);
        wr(SHPP_OFF_LATCH, 8'h96);
        chs(1'b0);
        i_shpp_periph.put(8'h00, 1'b0, 1'b1, seen);
        chk(seen, 8'h96);
        chs(1'b1);
        rd(SHPP_OFF_CTRL, 8'h98);
        wr(SHPP_OFF_LATCH, 8'h69);
        rd(SHPP_OFF_CTRL, 8'h18);
        wr(SHPP_OFF_CTRL, 8'h20);
        wr(SHPP_OFF_DIR, 8'hff);
        wr(SHPP_OFF_BIDIR, 8'hf0);
        repeat (4) @(posedge pclk);
        chk(bidir_oe, 8'h0f);
        chk(bidir_out, 8'h00);
        wr(SHPP_OFF_CTRL, 8'h00);
        wr(SHPP_OFF_MODE, 8'h00);
        wr(SHPP_OFF_OUT, 8'h11);
        cnt();
        chk(8'(n), 8'h00);
        wr(SHPP_OFF_MODE, 8'h01);
    endtask : t_out_hs
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {err_total, checked, n, act} = '0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        t_regs();
        t_simple();
        t_latch();
        t_in_hs();
        t_out_hs();
        close_out();
    end
endmodule : shpp_port_tb
